//--- logic/fcf_consts.svh
// constants of the fifo block
`ifndef FCF_CONSTS_SVH
`define FCF_CONSTS_SVH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define FCF_REG_STATUS    4'h0
`define FCF_REG_COUNT     4'h4
`define FCF_REG_OFFSETS   4'h8
`define FCF_REG_CTRL      4'hC
`define FCF_CTRL_FLUSH    0
// ---------------------------------------------------------------
// storage and timing
// ---------------------------------------------------------------
`define FCF_DEPTH         13'h1000
`define FCF_HALF          13'h0800
`define FCF_FILL_EDGES    2'h3
`define FCF_OFF_RESET     12'h07F
// presets by {load, sel1, sel0}
`define FCF_OFF_0         12'h07F
`define FCF_OFF_1         12'h0FF
`define FCF_OFF_2         12'h1FF
`define FCF_OFF_3         12'h3FF
`define FCF_OFF_4         12'h007
`define FCF_OFF_5         12'h00F
`define FCF_OFF_6         12'h01F
`define FCF_OFF_7         12'h03F
`define FCF_SER_BITS      5'h18
`endif

//--- logic/fcf_pkg.sv
// fifo block types
package fcf_pkg;
    // sampled pin group
    typedef struct packed {
        logic        rclk;
        logic        wclk;
        logic        ren_n;
        logic        wen_n;
        logic        ofs_n;
        logic        sen_n;
        logic        si;
        logic        mres;
        logic        rsel;
        logic        wsel;
        logic        bord;
        logic        par;
        logic        inw;
        logic        outw;
        logic        osel1;
        logic        osel0;
        logic [17:0] data;
    } fcf_pins_t;
    // straps captured at master reset
    typedef struct packed {
        logic read_sync;
        logic write_sync;
        logic little_endian;
        logic parity_interspersed;
        logic fall;
        logic in_narrow;
        logic out_narrow;
    } fcf_cfg_t;
    // fall-through output state
    typedef enum logic [2:0] {
        FCF_RD_EMPTY = 3'b001,
        FCF_RD_FILL  = 3'b010,
        FCF_RD_VALID = 3'b100
    } fcf_rd_state_t;
    // state of the block apart from the byte storage
    typedef struct packed {
        fcf_pins_t     s1;
        fcf_pins_t     s2;
        fcf_pins_t     s3;
        fcf_cfg_t      cfg;
        logic [11:0]   wptr;
        logic [11:0]   rptr;
        logic [12:0]   count;
        fcf_rd_state_t rd_state;
        logic [1:0]    fill_cnt;
        logic [17:0]   q;
        logic          ef_n;
        logic          ff_n;
        logic          hlf_n;
        logic          ae_n;
        logic          af_n;
        logic          clk_echo;
        logic          ren_echo_n;
        logic [11:0]   off_e;
        logic [11:0]   off_f;
        logic          par_sel;
        logic [23:0]   ser_shift;
        logic [4:0]    ser_cnt;
        logic          ack;
        logic [31:0]   rdata;
        logic          flush;
    } fcf_state_t;
endpackage

//--- logic/fcf_top.sv
// fifo with strap capture, bus matching and flags
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "fcf_consts.svh"
module fcf_top import fcf_pkg::*; (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        master_reset_in,
    input  wire logic        read_port_timing_select_in,
    input  wire logic        write_port_timing_select_in,
    input  wire logic        byte_order_select_in,
    input  wire logic        parity_placement_select_in,
    input  wire logic        input_width_select_in,
    input  wire logic        output_width_select_in,
    input  wire logic        default_offset_sel0_in,
    input  wire logic        default_offset_sel1_in,
    input  wire logic        offset_load_select_n_in,
    input  wire logic        fallthrough_or_serial_in,
    input  wire logic        serial_enable_n_in,
    input  wire logic        write_clk_in,
    input  wire logic        write_enable_n_in,
    input  wire logic [17:0] write_data_in,
    input  wire logic        read_clk_in,
    input  wire logic        read_enable_n_in,
    output logic      [17:0] read_data_out,
    output logic             empty_or_output_ready_n_out,
    output logic             full_or_input_ready_n_out,
    output logic             half_full_flag_n_out,
    output logic             almost_empty_flag_n_out,
    output logic             almost_full_flag_n_out,
    output logic             read_clock_echo_out,
    output logic             read_enable_echo_n_out,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // rising edge between samples
    function automatic logic rise(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction

    // preset offset table
    function automatic logic [11:0] preset_off(input logic [2:0] idx);
        unique case (idx)
            3'h0: return `FCF_OFF_0;
            3'h1: return `FCF_OFF_1;
            3'h2: return `FCF_OFF_2;
            3'h3: return `FCF_OFF_3;
            3'h4: return `FCF_OFF_4;
            3'h5: return `FCF_OFF_5;
            3'h6: return `FCF_OFF_6;
            3'h7: return `FCF_OFF_7;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // storage, one 9-bit byte per location
    // ---------------------------------------------------------------
    logic [8:0]  mem [0:4095];
    logic [1:0]  mem_we;
    logic [11:0] mem_a0;
    logic [11:0] mem_a1;
    logic [8:0]  mem_b0;
    logic [8:0]  mem_b1;

    fcf_state_t  r_q;
    fcf_state_t  r_d;
    fcf_pins_t   pins;

    // pin group for the synchroniser
    always_comb begin
        pins.rclk  = read_clk_in;
        pins.wclk  = write_clk_in;
        pins.ren_n = read_enable_n_in;
        pins.wen_n = write_enable_n_in;
        pins.ofs_n = offset_load_select_n_in;
        pins.sen_n = serial_enable_n_in;
        pins.si    = fallthrough_or_serial_in;
        pins.mres  = master_reset_in;
        pins.rsel  = read_port_timing_select_in;
        pins.wsel  = write_port_timing_select_in;
        pins.bord  = byte_order_select_in;
        pins.par   = parity_placement_select_in;
        pins.inw   = input_width_select_in;
        pins.outw  = output_width_select_in;
        pins.osel1 = default_offset_sel1_in;
        pins.osel0 = default_offset_sel0_in;
        pins.data  = write_data_in;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        fcf_pins_t   p;
        logic        wr_op;
        logic        rd_op;
        logic        rclk_rise;
        logic [12:0] wr_unit;
        logic [12:0] rd_unit;
        logic [12:0] free;
        logic [12:0] add;
        logic [12:0] sub;
        logic        load_q;
        logic [8:0]  rb0;
        logic [8:0]  rb1;
        logic [11:0] par_val;
        logic        req;
        p         = r_q.s2;
        r_d       = r_q;
        r_d.s1    = pins;
        r_d.s2    = r_q.s1;
        r_d.s3    = r_q.s2;
        mem_we    = 2'h0;
        mem_a0    = r_q.wptr;
        mem_a1    = r_q.wptr + 12'h001;
        mem_b0    = 9'h000;
        mem_b1    = 9'h000;
        add       = 13'h0000;
        sub       = 13'h0000;
        load_q    = 1'b0;
        par_val   = 12'h000;
        req       = 1'b0;
        rb0       = mem[r_q.rptr];
        rb1       = mem[r_q.rptr + 12'h001];
        rclk_rise = rise(r_q.s3.rclk, p.rclk);
        wr_unit   = r_q.cfg.in_narrow ? 13'h0001 : 13'h0002;
        rd_unit   = r_q.cfg.out_narrow ? 13'h0001 : 13'h0002;
        free      = `FCF_DEPTH - r_q.count;
        // sync: enable at clock rise; async: enable edge
        wr_op = r_q.cfg.write_sync ? (rise(r_q.s3.wclk, p.wclk) & ~p.wen_n)
                                   : rise(r_q.s3.wen_n, p.wen_n);
        rd_op = r_q.cfg.read_sync ? (rclk_rise & ~p.ren_n)
                                  : rise(p.ren_n, r_q.s3.ren_n);
        if (p.mres) begin
            // capture straps while master reset is held
            r_d.cfg.read_sync           = p.rsel;
            r_d.cfg.write_sync          = p.wsel;
            r_d.cfg.little_endian       = p.bord;
            r_d.cfg.parity_interspersed = p.par;
            r_d.cfg.fall                = p.si;
            r_d.cfg.in_narrow           = p.inw;
            r_d.cfg.out_narrow          = p.outw;
            r_d.off_e     = preset_off({p.ofs_n, p.osel1, p.osel0});
            r_d.off_f     = preset_off({p.ofs_n, p.osel1, p.osel0});
            r_d.wptr      = 12'h000;
            r_d.rptr      = 12'h000;
            r_d.count     = 13'h0000;
            r_d.q         = 18'h00000;
            r_d.rd_state  = FCF_RD_EMPTY;
            r_d.fill_cnt  = 2'h0;
            r_d.par_sel   = 1'b0;
            r_d.ser_cnt   = 5'h00;
            r_d.flush     = 1'b0;
        end else if (r_q.flush) begin
            // flush keeps straps and offsets
            r_d.wptr     = 12'h000;
            r_d.rptr     = 12'h000;
            r_d.count    = 13'h0000;
            r_d.q        = 18'h00000;
            r_d.rd_state = FCF_RD_EMPTY;
            r_d.fill_cnt = 2'h0;
            r_d.flush    = 1'b0;
        end else if (~p.ofs_n) begin
            // offset load: serial on write clock, else parallel
            if (rise(r_q.s3.wclk, p.wclk) && !p.sen_n) begin
                r_d.ser_shift = {r_q.ser_shift[22:0], p.si};
                r_d.ser_cnt   = r_q.ser_cnt + 5'h01;
                if (r_q.ser_cnt == `FCF_SER_BITS - 5'h01) begin
                    r_d.off_e   = r_q.ser_shift[22:11];
                    r_d.off_f   = {r_q.ser_shift[10:0], p.si};
                    r_d.ser_cnt = 5'h00;
                end
            end else if (wr_op) begin
                par_val = r_q.cfg.parity_interspersed
                        ? {p.data[12:9], p.data[7:0]}
                        : p.data[11:0];
                if (r_q.par_sel) begin
                    r_d.off_f = par_val;
                end else begin
                    r_d.off_e = par_val;
                end
                r_d.par_sel = ~r_q.par_sel;
            end
        end else begin
            // data write, byte order chosen by strap
            if (wr_op && free >= wr_unit) begin
                if (r_q.cfg.in_narrow) begin
                    mem_we = 2'h1;
                    mem_b0 = p.data[8:0];
                end else begin
                    mem_we = 2'h3;
                    mem_b0 = r_q.cfg.little_endian ? p.data[8:0] : p.data[17:9];
                    mem_b1 = r_q.cfg.little_endian ? p.data[17:9] : p.data[8:0];
                end
                r_d.wptr = r_q.wptr + wr_unit[11:0];
                add      = wr_unit;
            end
            // read side: standard on request, fall-through self-loads
            if (r_q.cfg.fall) begin
                unique case (r_q.rd_state)
                    FCF_RD_EMPTY: begin
                        if (r_q.count >= rd_unit) begin
                            r_d.rd_state = FCF_RD_FILL;
                            r_d.fill_cnt = 2'h0;
                        end
                    end
                    FCF_RD_FILL: begin
                        if (rclk_rise) begin
                            r_d.fill_cnt = r_q.fill_cnt + 2'h1;
                            if (r_q.fill_cnt == `FCF_FILL_EDGES - 2'h1) begin
                                load_q       = 1'b1;
                                r_d.rd_state = FCF_RD_VALID;
                            end
                        end
                    end
                    FCF_RD_VALID: begin
                        if (rd_op) begin
                            if (r_q.count >= rd_unit) begin
                                load_q = 1'b1;
                            end else begin
                                r_d.rd_state = FCF_RD_EMPTY;
                            end
                        end
                    end
                endcase
            end else if (rd_op && r_q.count >= rd_unit) begin
                load_q = 1'b1;
            end
            if (load_q) begin
                if (r_q.cfg.out_narrow) begin
                    r_d.q = {9'h000, rb0};
                end else begin
                    r_d.q = r_q.cfg.little_endian ? {rb1, rb0} : {rb0, rb1};
                end
                r_d.rptr = r_q.rptr + rd_unit[11:0];
                sub      = rd_unit;
            end
            r_d.count = r_q.count + add - sub;
        end
        // flags, all active low
        free        = `FCF_DEPTH - r_d.count;
        r_d.ef_n    = r_d.cfg.fall ? (r_d.rd_state != FCF_RD_VALID)
                                   : (r_d.count >= rd_unit);
        r_d.ff_n    = r_d.cfg.fall ? (free < wr_unit)
                                   : (free >= wr_unit);
        r_d.hlf_n   = ~(r_d.count > `FCF_HALF);
        r_d.ae_n    = ~(r_d.count < {1'b0, r_d.off_e});
        r_d.af_n    = ~(free <= {1'b0, r_d.off_f});
        // echoes only with a sync read port
        r_d.clk_echo   = r_q.cfg.read_sync & p.rclk;
        r_d.ren_echo_n = ~r_q.cfg.read_sync | p.ren_n;
        // bus slave: one wait cycle, then answer
        req     = avs_read_in | avs_write_in;
        r_d.ack = req & ~r_q.ack;
        if (req && !r_q.ack) begin
            unique case (avs_address_in)
                `FCF_REG_STATUS:  r_d.rdata = {18'h00000, r_q.rd_state == FCF_RD_VALID, r_q.af_n,
                                               r_q.ae_n, r_q.hlf_n, r_q.ff_n, r_q.ef_n, 1'b0, r_q.cfg};
                `FCF_REG_COUNT:   r_d.rdata = {19'h00000, r_q.count};
                `FCF_REG_OFFSETS: r_d.rdata = {4'h0, r_q.off_f, 4'h0, r_q.off_e};
                default:          r_d.rdata = 32'h00000000;
            endcase
            if (avs_write_in && avs_address_in == `FCF_REG_CTRL && !p.mres) begin
                r_d.flush = avs_writedata_in[`FCF_CTRL_FLUSH];
            end
        end
    end

    // ---------------------------------------------------------------
    // state register; reset clears straps
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r_q            <= '0;
            r_q.cfg        <= 7'h00;
            r_q.rd_state   <= FCF_RD_EMPTY;
            r_q.ef_n       <= 1'b0;
            r_q.ff_n       <= 1'b1;
            r_q.hlf_n      <= 1'b1;
            r_q.ae_n       <= 1'b0;
            r_q.af_n       <= 1'b1;
            r_q.s1.wen_n   <= 1'b1;
            r_q.s2.wen_n   <= 1'b1;
            r_q.s3.wen_n   <= 1'b1;
            r_q.ren_echo_n <= 1'b1;
            r_q.off_e      <= `FCF_OFF_RESET;
            r_q.off_f      <= `FCF_OFF_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // byte writes into storage
    always_ff @(posedge clk_sys_in) begin
        if (mem_we[0]) begin
            mem[mem_a0] <= mem_b0;
        end
        if (mem_we[1]) begin
            mem[mem_a1] <= mem_b1;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign read_data_out               = r_q.q;
    assign empty_or_output_ready_n_out = r_q.ef_n;
    assign full_or_input_ready_n_out   = r_q.ff_n;
    assign half_full_flag_n_out        = r_q.hlf_n;
    assign almost_empty_flag_n_out     = r_q.ae_n;
    assign almost_full_flag_n_out      = r_q.af_n;
    assign read_clock_echo_out         = r_q.clk_echo;
    assign read_enable_echo_n_out      = r_q.ren_echo_n;
    assign avs_readdata_out            = r_q.rdata;
    assign avs_waitrequest_out         = (avs_read_in | avs_write_in) & ~r_q.ack;
endmodule // fcf_top

//--- dv/fcf_chk.sv
// port-level checker of master reset, echoes, flags and bus
`timescale 1ns/1ps
module fcf_chk (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        master_reset_in,
    input wire logic        read_port_timing_select_in,
    input wire logic        fallthrough_or_serial_in,
    input wire logic        read_clk_in,
    input wire logic        read_enable_n_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic        avs_waitrequest_out,
    input wire logic [17:0] read_data_out,
    input wire logic        empty_or_output_ready_n_out,
    input wire logic        full_or_input_ready_n_out,
    input wire logic        half_full_flag_n_out,
    input wire logic        almost_empty_flag_n_out,
    input wire logic        almost_full_flag_n_out,
    input wire logic        read_clock_echo_out,
    input wire logic        read_enable_echo_n_out
);
    // ----
    // strap copy
    // ----
    logic       rs_q;
    logic       ft_q;
    logic [3:0] set_q;
    wire        ok = (set_q == 4'hF);
    // strap copy at master reset, then settle wait
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rs_q  <= 1'b0;
            ft_q  <= 1'b0;
            set_q <= 4'hF;
        end else if (master_reset_in) begin
            rs_q  <= read_port_timing_select_in;
            ft_q  <= fallthrough_or_serial_in;
            set_q <= 4'h0;
        end else if (!ok) begin
            set_q <= set_q + 4'h1;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_req_start;
        (avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in);
    endsequence
    sequence s_one_wait;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    a_bus_one_wait: assert property (s_req_start |-> s_one_wait)
        else $error("bus wait not one cycle");
    a_mreset_clear: assert property (master_reset_in [*8] |-> read_data_out == 18'h0 &&
        half_full_flag_n_out && almost_full_flag_n_out && !almost_empty_flag_n_out)
        else $error("master reset not clearing");
    a_echo_off: assert property (ok && !rs_q |-> !read_clock_echo_out && read_enable_echo_n_out)
        else $error("echo driven with async read port");
    a_echo_clk: assert property ((ok && rs_q && read_clk_in) [*4] |=> read_clock_echo_out)
        else $error("read clock echo missing");
    a_echo_ren: assert property ((ok && rs_q && !read_enable_n_in) [*6] |=> !read_enable_echo_n_out)
        else $error("read enable echo missing");
    a_std_excl: assert property (ok && !ft_q |-> empty_or_output_ready_n_out || full_or_input_ready_n_out)
        else $error("empty and full both shown");
    a_empty_ae: assert property (ok && !ft_q && !empty_or_output_ready_n_out |-> !almost_empty_flag_n_out)
        else $error("empty without almost empty");
    a_full_hf: assert property (ok && !ft_q && !full_or_input_ready_n_out |-> !half_full_flag_n_out)
        else $error("full without half full");
endmodule // fcf_chk

//--- dv/fcf_partner.sv
// far-side port logic: one 160 ns clock frame per request
`timescale 1ns/1ps
module fcf_partner (
    input  wire logic       clk_sys_in,
    input  wire logic       go_in,
    input  wire logic [1:0] kind_in,
    input  wire logic       quiet_in,
    input  wire logic       async_in,
    output logic            wclk_out,
    output logic            rclk_out,
    output logic            wen_n_out,
    output logic            ren_n_out,
    output logic            done_out
);
    logic       busy_q = 1'b0;
    logic [2:0] cnt_q  = 3'h0;
    logic       done_q = 1'b0;
    wire        en     = busy_q && !quiet_in && (!async_in || !cnt_q[2]);
    // eight-clock frame, done until request drops
    always_ff @(posedge clk_sys_in) begin
        if (busy_q) begin
            cnt_q  <= cnt_q + 3'h1;
            busy_q <= (cnt_q != 3'h7);
            done_q <= (cnt_q == 3'h7);
        end else if (go_in && !done_q) begin
            busy_q <= 1'b1;
        end else if (!go_in) begin
            done_q <= 1'b0;
        end
    end
    // clocks idle low; async port sees only enable
    assign wclk_out  = busy_q && !async_in && (kind_in == 2'h0) && cnt_q[2];
    assign rclk_out  = busy_q && !async_in && (kind_in != 2'h0) && cnt_q[2];
    assign wen_n_out = !(en && kind_in == 2'h0);
    assign ren_n_out = !(en && kind_in == 2'h1);
    assign done_out  = done_q;
endmodule // fcf_partner

//--- dv/fcf_top_bench.sv
// self-checking bench of the fifo block
`timescale 1ns/1ps
`include "fcf_consts.svh"
module fcf_top_bench;
    // ----
    // pins, bus and model state
    // ----
    logic        clk_sys_in = 1'b0, rst_in = 1'b1, mres = 1'b0, ofs_n = 1'b1, si = 1'b0, sen_n = 1'b1;
    logic        go = 1'b0, quiet = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        wclk, rclk, wen_n, ren_n, done, ef_n, ff_n, hlf_n, ae_n, af_n, eck, ren_e, wreq;
    logic [1:0]  kind = 2'h0;
    logic [3:0]  adr = 4'h0;
    logic [9:0]  st = 10'h0, c = 10'h0;
    logic [17:0] wdat = 18'h0, rdat, exp_d = 18'h0;
    logic [31:0] wd = 32'h0, rdv, v, rnd = 32'h13DB5524, cyc = 32'h0;
    logic [11:0] off_e, off_f;
    logic [11:0] offs[8] = '{`FCF_OFF_0, `FCF_OFF_1, `FCF_OFF_2, `FCF_OFF_3,
                             `FCF_OFF_4, `FCF_OFF_5, `FCF_OFF_6, `FCF_OFF_7};
    logic [8:0]  q[$];
    int          failures = 0, samples_checked = 0;
    fcf_top i_dut (.clk_sys_in, .rst_in, .master_reset_in(mres), .read_port_timing_select_in(st[9]),
        .write_port_timing_select_in(st[8]), .byte_order_select_in(st[7]), .parity_placement_select_in(st[6]),
        .input_width_select_in(st[5]), .output_width_select_in(st[4]), .default_offset_sel1_in(st[3]),
        .default_offset_sel0_in(st[2]), .offset_load_select_n_in(ofs_n), .fallthrough_or_serial_in(si),
        .serial_enable_n_in(sen_n), .write_clk_in(wclk), .write_enable_n_in(wen_n), .write_data_in(wdat),
        .read_clk_in(rclk), .read_enable_n_in(ren_n), .read_data_out(rdat), .empty_or_output_ready_n_out(ef_n),
        .full_or_input_ready_n_out(ff_n), .half_full_flag_n_out(hlf_n), .almost_empty_flag_n_out(ae_n),
        .almost_full_flag_n_out(af_n), .read_clock_echo_out(eck), .read_enable_echo_n_out(ren_e),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdv), .avs_waitrequest_out(wreq));
    fcf_partner i_far (.clk_sys_in, .go_in(go), .kind_in(kind), .quiet_in(quiet),
        .async_in(kind == 2'h0 ? !c[8] : !c[9]), .wclk_out(wclk), .rclk_out(rclk),
        .wen_n_out(wen_n), .ren_n_out(ren_n), .done_out(done));
    // clock and hang guard
    initial forever #10 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd90000) begin
            failures++;
            final_report;
        end
    end
    // ----
    // tasks
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // request held until waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_sys_in); while (wreq !== 1'b0);
        v = rdv;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // master reset with straps s
    task automatic mreset(input logic [9:0] s);
        st <= s;
        ofs_n <= s[1];
        si <= s[0];
        mres <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        mres <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        ofs_n <= 1'b1;
        si <= rnd[5];
        st <= rnd[9:0]; // straps wander
        repeat (5) @(posedge clk_sys_in);
        c = s;
        q.delete();
        exp_d = 18'h0;
        off_e = offs[{s[1], s[3], s[2]}];
        off_f = off_e;
    endtask
    // frame k: 0 write, 1 read, 2 read clock
    task automatic xfer(input logic [1:0] k, input logic qt, input logic [17:0] d);
        logic [8:0] a0, a1;
        kind <= k;
        quiet <= qt;
        wdat <= d;
        go <= 1'b1;
        do @(posedge clk_sys_in); while (done !== 1'b1);
        go <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        a0 = c[7] ? d[8:0] : d[17:9];
        a1 = c[7] ? d[17:9] : d[8:0];
        if (k == 2'h0 && !qt && q.size() < (c[5] ? 4096 : 4095)) begin
            if (!c[5]) q.push_back(a0);
            q.push_back(c[5] ? d[8:0] : a1);
        end
        if (k == 2'h1 && q.size() >= (c[4] ? 1 : 2)) begin
            a0 = q.pop_front();
            exp_d = c[4] ? {9'h0, a0} : (c[7] ? {q[0], a0} : {a0, q[0]});
            if (!c[4]) void'(q.pop_front());
        end
        if (k == 2'h1 && !c[0]) check(rdat, exp_d);
        if (!qt && !c[0]) begin
            check(ef_n, q.size() >= (c[4] ? 1 : 2));
            check(ff_n, q.size() < `FCF_DEPTH);
            check(hlf_n, q.size() <= `FCF_HALF);
            check(ae_n, q.size() >= off_e);
            check(af_n, `FCF_DEPTH - q.size() > off_f);
        end
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        logic [9:0] s;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        // each preset index, random straps
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            s = {rnd[9:4], i[1], i[0], i[2], rnd[0] & rnd[9]};
            mreset(s);
            bus(1'b0, `FCF_REG_STATUS, 32'h0);
            check(v[6:0], {s[9:6], s[0], s[5:4]});
            check(v[9:8], {!s[0], s[0]});
            bus(1'b0, `FCF_REG_OFFSETS, 32'h0);
            check(v, {4'h0, off_f, 4'h0, off_e});
        end
        bus(1'b0, 4'h2, 32'h0);
        check(v, 32'h0);
        $display("test straps done");
        // four width pairs
        for (int m = 0; m < 4; m++) begin
            rnd = lfsr(rnd);
            mreset({rnd[9:6], m[1], m[0], rnd[3:1], 1'b0});
            repeat (3) begin
                rnd = lfsr(rnd);
                xfer(2'h0, 1'b0, c[5] ? {9'h0, rnd[8:0]} : rnd[17:0]);
            end
            bus(1'b0, `FCF_REG_COUNT, 32'h0);
            check(v, q.size());
            repeat (7) xfer(2'h1, 1'b0, 18'h0);
        end
        $display("test widths done");
        // fall-through first word
        mreset(10'h303);
        xfer(2'h0, 1'b0, 18'h2A5C3);
        check(ef_n, 1'b1);
        repeat (3) xfer(2'h2, 1'b1, 18'h0);
        check(rdat, 18'h2A5C3);
        check(ef_n, 1'b0);
        check(ff_n, 1'b0);
        xfer(2'h1, 1'b0, 18'h0);
        check(ef_n, 1'b1);
        $display("test fall-through done");
        // fill, last write refused
        mreset(10'h302);
        for (int k = 0; k < 2049; k++) begin
            rnd = lfsr(rnd);
            xfer(2'h0, 1'b0, rnd[17:0]);
        end
        bus(1'b0, `FCF_REG_COUNT, 32'h0);
        check(v, `FCF_DEPTH);
        // serial offsets, then flush
        rnd = lfsr(rnd);
        ofs_n <= 1'b0;
        sen_n <= 1'b0;
        for (int b = 23; b >= 0; b--) begin
            si <= rnd[b] | (b == 12);
            xfer(2'h0, 1'b1, 18'h0);
        end
        ofs_n <= 1'b1;
        sen_n <= 1'b1;
        @(posedge clk_sys_in);
        bus(1'b0, `FCF_REG_OFFSETS, 32'h0);
        check(v, {4'h0, rnd[11:0], 4'h0, rnd[23:13], 1'b1});
        bus(1'b1, `FCF_REG_CTRL, 32'h1);
        bus(1'b0, `FCF_REG_COUNT, 32'h0);
        check(v, 32'h0);
        $display("test fill and serial done");
        final_report;
    end
endmodule // fcf_top_bench
bind fcf_top fcf_chk i_chk (.clk_sys_in, .rst_in, .master_reset_in, .read_port_timing_select_in,
    .fallthrough_or_serial_in, .read_clk_in, .read_enable_n_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .read_data_out, .empty_or_output_ready_n_out, .full_or_input_ready_n_out,
    .half_full_flag_n_out, .almost_empty_flag_n_out, .almost_full_flag_n_out, .read_clock_echo_out,
    .read_enable_echo_n_out);
